// *** logic/gio_pkg.sv ***
package gio_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] GIO_CFG_OFS = 8'h00;
   localparam logic [7:0] GIO_STAT_OFS = 8'h04;

   // ------------------------------------------------------------
   // configuration fields
   // ------------------------------------------------------------
   localparam int GIO_CFG_W = 18;
   localparam int GIO_MODE_LSB = 0;
   localparam int GIO_IN_REG_BIT = 3;
   localparam int GIO_OUT_REG_BIT = 4;
   localparam int GIO_OE_REG_BIT = 5;
   localparam int GIO_IN_FALL_BIT = 6;
   localparam int GIO_OUT_FALL_BIT = 7;
   localparam int GIO_OE_FALL_BIT = 8;
   localparam int GIO_INVERT_BIT = 9;
   localparam int GIO_DDR_BIT = 10;
   localparam int GIO_ALIGN_LSB = 11;
   localparam int GIO_SERDES_BIT = 13;
   localparam int GIO_PULL_DN_BIT = 14;
   localparam int GIO_HOLD_BIT = 15;
   localparam int GIO_DYN_PU_BIT = 16;
   localparam int GIO_USER_BIT = 17;
   localparam logic [GIO_CFG_W-1:0] GIO_CFG_RST = 18'h00000;
   localparam logic [GIO_CFG_W-1:0] GIO_HS_ONLY_MASK = 18'h1A000;

   // ------------------------------------------------------------
   // data widths
   // ------------------------------------------------------------
   localparam int GIO_CORE_W = 4;
   localparam int GIO_DDR_W = 2;

   typedef enum logic [2:0]
   {
      GIO_UNUSED = 3'h0,
      GIO_INPUT = 3'h1,
      GIO_OUTPUT = 3'h2,
      GIO_BIDIR = 3'h3,
      GIO_CLKOUT = 3'h4,
      GIO_BYPASS = 3'h5
   } gio_mode_e;

   typedef enum logic [1:0]
   {
      GIO_AL_NORMAL = 2'h0,
      GIO_AL_RESYNC = 2'h1,
      GIO_AL_PIPE = 2'h2
   } gio_align_e;

endpackage

// *** logic/gio_ser4.sv ***
`timescale 1ns/100ps
module gio_ser4 #(
   parameter int WIDTH = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ser_in,
   input wire logic [WIDTH-1:0] par_in,
   output logic [WIDTH-1:0] par_out,
   output logic word_strobe,
   output logic ser_out
);

   if (WIDTH < 2)
   begin : g_width_check
      $error("gio_ser4 needs at least two bits");
   end

   logic [$clog2(WIDTH)-1:0] cnt_ff;
   logic [WIDTH-1:0] rx_sh_ff;
   logic [WIDTH-1:0] tx_sh_ff;
   logic [WIDTH-1:0] word_ff;
   logic strobe_ff;
   wire last_bit = (cnt_ff == ($clog2(WIDTH))'(WIDTH - 1));
   // newest bit enters at the top, so the earliest ends at bit 0
   wire [WIDTH-1:0] nxt_rx_sh = {ser_in, rx_sh_ff[WIDTH-1:1]};

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_ff <= '0;
         rx_sh_ff <= '0;
         tx_sh_ff <= '0;
         word_ff <= '0;
         strobe_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= last_bit ? '0 : cnt_ff + 1'b1;
         rx_sh_ff <= nxt_rx_sh;
         strobe_ff <= last_bit;
         if (last_bit)
         begin
            word_ff <= nxt_rx_sh;
            tx_sh_ff <= par_in;
         end
         else
         begin
            tx_sh_ff <= {1'b0, tx_sh_ff[WIDTH-1:1]};
         end
      end
   end

   assign par_out = word_ff;
   assign word_strobe = strobe_ff;
   assign ser_out = tx_sh_ff[0];

endmodule // gio_ser4

// *** logic/gio_io_logic.sv ***
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
module gio_io_logic #(
   parameter bit HIGH_SPEED = 1'b1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [gio_pkg::GIO_CORE_W-1:0] core_out,
   input wire logic core_oe,
   output logic [gio_pkg::GIO_CORE_W-1:0] core_in,
   output logic core_word_strobe,
   input wire logic clk_tree,
   output logic bypass_input,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_pull_up,
   output logic pad_pull_down,
   output logic pad_hold
);

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------
   logic [gio_pkg::GIO_CFG_W-1:0] cfg_ff;
   logic [31:0] rdata_ff;
   logic [1:0] cfg_age_ff;
   wire cfg_sel = (reg_addr == gio_pkg::GIO_CFG_OFS);
   wire stat_sel = (reg_addr == gio_pkg::GIO_STAT_OFS);
   // features absent on high-voltage pins stay cleared
   wire [gio_pkg::GIO_CFG_W-1:0] hs_mask = HIGH_SPEED ? '1 : ~gio_pkg::GIO_HS_ONLY_MASK;
   wire [gio_pkg::GIO_CFG_W-1:0] nxt_cfg = reg_wdata[gio_pkg::GIO_CFG_W-1:0] & hs_mask;

   gio_pkg::gio_mode_e mode;
   gio_pkg::gio_align_e align;
   assign mode = gio_pkg::gio_mode_e'(cfg_ff[gio_pkg::GIO_MODE_LSB +: 3]);
   assign align = gio_pkg::gio_align_e'(cfg_ff[gio_pkg::GIO_ALIGN_LSB +: 2]);

   wire user_mode = cfg_ff[gio_pkg::GIO_USER_BIT];
   wire in_reg_en = cfg_ff[gio_pkg::GIO_IN_REG_BIT];
   wire out_reg_en = cfg_ff[gio_pkg::GIO_OUT_REG_BIT];
   wire oe_reg_en = cfg_ff[gio_pkg::GIO_OE_REG_BIT];
   wire in_fall = cfg_ff[gio_pkg::GIO_IN_FALL_BIT];
   wire out_fall = cfg_ff[gio_pkg::GIO_OUT_FALL_BIT];
   wire oe_fall = cfg_ff[gio_pkg::GIO_OE_FALL_BIT];
   wire out_invert = cfg_ff[gio_pkg::GIO_INVERT_BIT];
   wire double_edge_mode = cfg_ff[gio_pkg::GIO_DDR_BIT];
   wire serdes_en = cfg_ff[gio_pkg::GIO_SERDES_BIT];
   wire pull_dn_sel = cfg_ff[gio_pkg::GIO_PULL_DN_BIT];
   wire hold_en = cfg_ff[gio_pkg::GIO_HOLD_BIT];
   wire dyn_pu_en = cfg_ff[gio_pkg::GIO_DYN_PU_BIT];

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   wire m_unused = !user_mode || (mode == gio_pkg::GIO_UNUSED);
   wire m_clk = user_mode && (mode == gio_pkg::GIO_CLKOUT);
   wire m_byp = user_mode && (mode == gio_pkg::GIO_BYPASS);
   wire m_bidir = user_mode && (mode == gio_pkg::GIO_BIDIR);
   wire m_out = user_mode && (mode == gio_pkg::GIO_OUTPUT);
   wire rx_en = user_mode && ((mode == gio_pkg::GIO_INPUT) || m_bidir);
   wire tx_en = m_out || m_bidir;
   wire ser_act = serdes_en && !double_edge_mode;
   wire al_rise = (align != gio_pkg::GIO_AL_NORMAL);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_ff <= gio_pkg::GIO_CFG_RST;
         cfg_age_ff <= 2'h0;
      end
      else
      begin
         if (reg_wr && cfg_sel)
         begin
            cfg_ff <= nxt_cfg;
         end
         cfg_age_ff <= (reg_wr && cfg_sel) ? 2'h0 : ((cfg_age_ff == 2'h3) ? 2'h3 : cfg_age_ff + 2'h1);
      end
   end

   // ------------------------------------------------------------
   // receive capture registers
   // ------------------------------------------------------------
   logic in_pos_ff;
   logic in_neg_ff;
   logic [gio_pkg::GIO_DDR_W-1:0] rsy_ff;
   logic [gio_pkg::GIO_DDR_W-1:0] pip_ff;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         in_pos_ff <= 1'b0;
      end
      else
      begin
         in_pos_ff <= pad_in;
      end
   end

   always_ff @(negedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         in_neg_ff <= 1'b0;
      end
      else
      begin
         in_neg_ff <= pad_in;
      end
   end

   // falling sample waits half a period to join the rising one
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rsy_ff <= '0;
         pip_ff <= '0;
      end
      else
      begin
         rsy_ff <= {in_neg_ff, in_pos_ff};
         pip_ff <= rsy_ff;
      end
   end

   wire rise_sample_bit = (align == gio_pkg::GIO_AL_NORMAL) ? in_pos_ff :
                          (align == gio_pkg::GIO_AL_RESYNC) ? rsy_ff[0] : pip_ff[0];
   wire fall_sample_bit = (align == gio_pkg::GIO_AL_NORMAL) ? in_neg_ff :
                          (align == gio_pkg::GIO_AL_RESYNC) ? rsy_ff[1] : pip_ff[1];
   wire rx_reg_bit = in_fall ? in_neg_ff : in_pos_ff;
   wire rx_bit = in_reg_en ? rx_reg_bit : pad_in;

   // ------------------------------------------------------------
   // serializer and deserializer
   // ------------------------------------------------------------
   logic [gio_pkg::GIO_CORE_W-1:0] des_word;
   logic des_strobe;
   logic ser_bit;

   gio_ser4 #(
      .WIDTH(gio_pkg::GIO_CORE_W)
   ) u_ser4 (
      .core_clk(core_clk),
      .rstn(rstn),
      .ser_in(pad_in),
      .par_in(core_out),
      .par_out(des_word),
      .word_strobe(des_strobe),
      .ser_out(ser_bit)
   );

   // ------------------------------------------------------------
   // core receive bus
   // ------------------------------------------------------------
   wire [gio_pkg::GIO_CORE_W-1:0] rx_word =
      !rx_en ? '0 :
      ser_act ? des_word :
      double_edge_mode ? {2'h0, fall_sample_bit, rise_sample_bit} :
      {3'h0, rx_bit};
   assign core_in = rx_word;
   assign core_word_strobe = rx_en && ser_act && des_strobe;

   // bypass is a plain gate, no register in its way
   assign bypass_input = m_byp && pad_in;

   // ------------------------------------------------------------
   // transmit and enable registers
   // ------------------------------------------------------------
   logic out_pos_ff;
   logic out_neg_ff;
   logic oe_pos_ff;
   logic oe_neg_ff;
   logic [gio_pkg::GIO_DDR_W-1:0] tx_al_ff;
   logic [gio_pkg::GIO_DDR_W-1:0] tx_pip_ff;
   logic ddr_p_ff;
   logic ddr_n_ff;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         out_pos_ff <= 1'b0;
         oe_pos_ff <= 1'b0;
         tx_al_ff <= '0;
         tx_pip_ff <= '0;
      end
      else
      begin
         out_pos_ff <= core_out[0];
         oe_pos_ff <= core_oe;
         tx_al_ff <= core_out[1:0];
         tx_pip_ff <= tx_al_ff;
      end
   end

   always_ff @(negedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         out_neg_ff <= 1'b0;
         oe_neg_ff <= 1'b0;
      end
      else
      begin
         out_neg_ff <= core_out[0];
         oe_neg_ff <= core_oe;
      end
   end

   // both bits enter on the rising edge in resync and pipeline mode
   wire [gio_pkg::GIO_DDR_W-1:0] launch_pair = (align == gio_pkg::GIO_AL_PIPE) ? tx_pip_ff : tx_al_ff;
   wire rise_launch_bit = al_rise ? launch_pair[0] : core_out[0];
   wire fall_launch_bit = al_rise ? launch_pair[1] : core_out[1];

   // xor pair merges two edge registers into one glitch-free stream
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ddr_p_ff <= 1'b0;
      end
      else
      begin
         ddr_p_ff <= rise_launch_bit ^ ddr_n_ff;
      end
   end

   always_ff @(negedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ddr_n_ff <= 1'b0;
      end
      else
      begin
         ddr_n_ff <= fall_launch_bit ^ ddr_p_ff;
      end
   end

   wire ddr_stream = ddr_p_ff ^ ddr_n_ff;
   wire tx_reg_bit = out_fall ? out_neg_ff : out_pos_ff;
   wire tx_regd = double_edge_mode ? ddr_stream : (ser_act ? ser_bit : tx_reg_bit);
   wire tx_bit = (out_reg_en || double_edge_mode || ser_act) ? (tx_regd ^ out_invert) : core_out[0];
   wire oe_reg_bit = oe_fall ? oe_neg_ff : oe_pos_ff;
   wire bidir_oe = oe_reg_en ? oe_reg_bit : core_oe;

   // ------------------------------------------------------------
   // pad driver, pull and hold
   // ------------------------------------------------------------
   wire drv_en = m_clk || m_out || (m_bidir && bidir_oe);
   assign pad_oe = drv_en;
   assign pad_out = !drv_en ? 1'b0 : (m_clk ? clk_tree : (tx_en ? tx_bit : 1'b0));
   // configuring: always pull-up; unused: selectable pull
   wire cfg_pull = !user_mode || (m_unused && !pull_dn_sel);
   wire dyn_pull = user_mode && dyn_pu_en && !drv_en;
   assign pad_pull_up = cfg_pull || dyn_pull;
   assign pad_pull_down = user_mode && m_unused && pull_dn_sel && !dyn_pull;
   assign pad_hold = user_mode && !m_unused && hold_en && !drv_en && !dyn_pull;

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   wire [31:0] stat_word = {23'h000000, core_in, pad_hold, pad_oe, pad_out, pad_in, 1'b0} >> 1;
   wire [31:0] nxt_rdata = cfg_sel ? {14'h0000, cfg_ff} : (stat_sel ? stat_word : 32'h00000000);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata_ff <= 32'h00000000;
      end
      else
      begin
         rdata_ff <= reg_rd ? nxt_rdata : 32'h00000000;
      end
   end

   assign reg_rdata = rdata_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   wire quiet = (cfg_age_ff == 2'h3) && !(reg_wr && cfg_sel);

   chk_config_pullup: assert property (@(posedge core_clk) disable iff (!rstn)
      !user_mode |-> (!pad_oe && pad_pull_up && !pad_pull_down))
      else $error("pin not pulled up during configuration");

   chk_unused_pull: assert property (@(posedge core_clk) disable iff (!rstn)
      (user_mode && m_unused && !dyn_pu_en) |-> (!pad_oe && (pad_pull_up == !pull_dn_sel) && (pad_pull_down == pull_dn_sel)))
      else $error("unused pin pull or tristate wrong");

   chk_bypass_path: assert property (@(posedge core_clk) disable iff (!rstn)
      m_byp |-> (core_in == '0 && bypass_input == pad_in && !pad_oe))
      else $error("bypass path not direct");

   chk_rx_rise_reg: assert property (@(posedge core_clk) disable iff (!rstn)
      (quiet && rx_en && in_reg_en && !in_fall && !double_edge_mode && !ser_act) |=> core_in[0] == $past(pad_in))
      else $error("registered receive bit wrong");

   chk_rx_resync_pair: assert property (@(posedge core_clk) disable iff (!rstn)
      (quiet && rx_en && double_edge_mode && align == gio_pkg::GIO_AL_RESYNC) ##1 quiet |->
      core_in[0] == $past(pad_in, 2))
      else $error("resync rising bit misaligned");

   chk_out_mode_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      m_out |-> (pad_oe && !pad_hold && !pad_pull_down))
      else $error("output mode driver off");

   chk_out_invert: assert property (@(posedge core_clk) disable iff (!rstn)
      (quiet && tx_en && out_reg_en && !out_fall && !double_edge_mode && !ser_act && pad_oe) |=>
      (!pad_oe || pad_out == ($past(core_out[0]) ^ out_invert)))
      else $error("output register or inversion wrong");

   chk_clock_out: assert property (@(posedge core_clk) disable iff (!rstn)
      m_clk |-> (pad_oe && pad_out == clk_tree))
      else $error("clock output not driven");

   chk_bidir_oe_reg: assert property (@(posedge core_clk) disable iff (!rstn)
      (quiet && m_bidir && oe_reg_en && !oe_fall) |=> pad_oe == $past(core_oe))
      else $error("registered enable wrong");

   // low phase of the pad shows the fall bit taken from the core since the last rising edge
   chk_ddr_out_fall: assert property (@(posedge core_clk) disable iff (!rstn)
      (quiet && m_out && double_edge_mode && align == gio_pkg::GIO_AL_NORMAL) |->
      pad_out == (core_out[1] ^ out_invert))
      else $error("double-edge output low phase wrong");

   chk_hold_idle: assert property (@(posedge core_clk) disable iff (!rstn)
      (m_bidir && hold_en && !dyn_pu_en && !pad_oe) |-> (pad_hold && !pad_pull_up && !pad_pull_down))
      else $error("bus hold not alone on idle pin");

   chk_hv_features: assert property (@(posedge core_clk) disable iff (!rstn)
      !HIGH_SPEED |-> (!pad_hold && !ser_act && !dyn_pu_en))
      else $error("high-speed feature on high-voltage pin");

endmodule // gio_io_logic

// *** tb/gio_pad_model.sv ***
`timescale 1ns/100ps
module gio_pad_model (
   input wire logic core_clk,
   input wire logic pad_out,
   input wire logic pad_oe,
   input wire logic pad_pull_up,
   input wire logic pad_pull_down,
   input wire logic pad_hold,
   input wire logic ext_val,
   input wire logic ext_en,
   output logic pad_in
);
   logic last_ff = 1'b0;

   // ------------------------------------------------------------
   // pad wire resolution
   // ------------------------------------------------------------
   // the pin driver wins; outside driver next; then the weak circuits
   always_comb
   begin
      if (pad_oe)
         pad_in = pad_out;
      else if (ext_en)
         pad_in = ext_val;
      else if (pad_pull_up)
         pad_in = 1'b1;
      else if (pad_pull_down)
         pad_in = 1'b0;
      else if (pad_hold)
         pad_in = last_ff;
      else
         pad_in = ~last_ff;
   end

   // floating wire shows no stable value
   always @(posedge core_clk)
      last_ff <= pad_in;
endmodule // gio_pad_model

// *** tb/gio_io_logic_tb.sv ***
`timescale 1ns/100ps
module gio_io_logic_tb;
   logic core_clk, rstn, reg_wr, reg_rd, core_oe, core_word_strobe, clk_tree, bypass_input;
   logic pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_hold, ext_val, ext_en;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [3:0] core_out, core_in, h;
   logic [2:0] ra, fb;
   logic v, p, a, b, o, d, e, po, pd;
   int n_mismatch = 0;
   int cmp_count = 0;
   int hits;

   gio_io_logic i_gio_io_logic (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_out(core_out), .core_oe(core_oe),
      .core_in(core_in), .core_word_strobe(core_word_strobe), .clk_tree(clk_tree), .bypass_input(bypass_input),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
      .pad_pull_down(pad_pull_down), .pad_hold(pad_hold));

   gio_pad_model i_gio_pad_model (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .pad_hold(pad_hold), .ext_val(ext_val),
      .ext_en(ext_en), .pad_in(pad_in));

   always #10 core_clk = ~core_clk;
   always #7 clk_tree = ~clk_tree;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   function automatic logic [31:0] bitv(input int pos);
      return 32'h1 << pos;
   endfunction

   function automatic logic [31:0] cfgw(input gio_pkg::gio_mode_e m, input logic [31:0] extra);
      return bitv(gio_pkg::GIO_USER_BIT) | 32'(m) | extra;
   endfunction

   task automatic reg_write(input logic [7:0] adr, input logic [31:0] dat);
      @(posedge core_clk);
      reg_addr <= adr;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] adr, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= adr;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", exp, reg_rdata);
   endtask

   // configuration change, then the quiet time the pin logic expects
   task automatic set_cfg(input gio_pkg::gio_mode_e m, input logic [31:0] extra);
      reg_write(gio_pkg::GIO_CFG_OFS, cfgw(m, extra));
      repeat (3) @(posedge core_clk);
   endtask

   initial
   begin
      #1900000;
      n_mismatch++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      clk_tree = 1'b0;
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      core_out = 4'h0;
      core_oe = 1'b0;
      ext_val = 1'b0;
      ext_en = 1'b0;
      void'($urandom(42553));
      repeat (5) @(posedge core_clk);
      #1;
      chk("pull_up_cfg", 1, pad_pull_up);
      chk("oe_cfg", 0, pad_oe);
      @(posedge core_clk);
      rstn <= 1'b1;
      reg_read(gio_pkg::GIO_CFG_OFS, 32'h0);
      reg_read(8'h10, 32'h0);
      set_cfg(gio_pkg::GIO_UNUSED, 32'h0);
      chk("oe_unused", 0, pad_oe);
      chk("pu_unused", 1, pad_pull_up);
      chk("pd_unused", 0, pad_pull_down);
      set_cfg(gio_pkg::GIO_UNUSED, bitv(gio_pkg::GIO_PULL_DN_BIT));
      chk("pd_sel", 1, pad_pull_down);
      chk("pu_sel", 0, pad_pull_up);
      reg_read(gio_pkg::GIO_CFG_OFS, cfgw(gio_pkg::GIO_UNUSED, bitv(gio_pkg::GIO_PULL_DN_BIT)));
      // combinational receive
      ext_en <= 1'b1;
      set_cfg(gio_pkg::GIO_INPUT, 32'h0);
      repeat (8)
      begin
         @(posedge core_clk);
         v = 1'($urandom);
         ext_val <= v;
         #1;
         chk("in_comb", v, core_in[0]);
         chk("in_oe", 0, pad_oe);
         chk("bypass_off", 0, bypass_input);
      end
      // registered receive, either edge
      for (int fe = 0; fe < 2; fe++)
      begin
         set_cfg(gio_pkg::GIO_INPUT, bitv(gio_pkg::GIO_IN_REG_BIT) | (32'(fe) << gio_pkg::GIO_IN_FALL_BIT));
         p = ext_val;
         repeat (8)
         begin
            @(posedge core_clk);
            v = 1'($urandom);
            ext_val <= v;
            #1;
            chk("in_reg_hold", p, core_in[0]);
            if (fe == 1)
               @(negedge core_clk);
            else
               @(posedge core_clk);
            #1;
            chk("in_reg_new", v, core_in[0]);
            p = v;
         end
      end
      // bypass path
      set_cfg(gio_pkg::GIO_BYPASS, 32'h0);
      repeat (6)
      begin
         @(posedge core_clk);
         v = 1'($urandom);
         ext_val <= v;
         #1;
         chk("bypass", v, bypass_input);
         chk("bypass_core", 0, core_in);
      end
      // double-edge receive in each alignment
      for (int al = 0; al < 3; al++)
      begin
         set_cfg(gio_pkg::GIO_INPUT, bitv(gio_pkg::GIO_IN_REG_BIT) | bitv(gio_pkg::GIO_DDR_BIT)
            | (32'(al) << gio_pkg::GIO_ALIGN_LSB));
         @(negedge core_clk);
         a = 1'($urandom);
         ext_val <= a;
         for (int k = 0; k < 10; k++)
         begin
            @(posedge core_clk);
            b = 1'($urandom);
            ext_val <= b;
            ra = {ra[1:0], a};
            #1;
            if (k >= 3 && al == 0)
               chk("ddr_rise", ra[0], core_in[0]);
            if (k >= 3 && al == 1)
               chk("ddr_resync", 32'({fb[0], ra[1]}), 32'(core_in[1:0]));
            if (k >= 3 && al == 2)
               chk("ddr_pipe", 32'({fb[1], ra[2]}), 32'(core_in[1:0]));
            @(negedge core_clk);
            fb = {fb[1:0], b};
            a = 1'($urandom);
            ext_val <= a;
            #1;
            if (k >= 3 && al == 0)
               chk("ddr_fall", b, core_in[1]);
         end
      end
      // deserializer: earliest bit lands on bit 0
      set_cfg(gio_pkg::GIO_INPUT, bitv(gio_pkg::GIO_SERDES_BIT));
      hits = 0;
      for (int k = 0; k < 16; k++)
      begin
         @(posedge core_clk);
         h = {ext_val, h[3:1]};
         ext_val <= 1'($urandom);
         #1;
         if (k >= 4 && core_word_strobe === 1'b1)
         begin
            hits++;
            chk("deser_word", h, core_in);
         end
      end
      chk("deser_strobes", 3, hits);
      // registered transmit, edge and inversion
      for (int c = 0; c < 4; c++)
      begin
         set_cfg(gio_pkg::GIO_OUTPUT, bitv(gio_pkg::GIO_OUT_REG_BIT)
            | (32'(c % 2) << gio_pkg::GIO_INVERT_BIT) | (32'(c / 2) << gio_pkg::GIO_OUT_FALL_BIT));
         p = core_out[0];
         repeat (8)
         begin
            @(posedge core_clk);
            v = 1'($urandom);
            core_out <= {3'($urandom), v};
            #1;
            chk("out_reg", p ^ 1'(c % 2), pad_out);
            chk("out_oe", 1, pad_oe);
            if (c >= 2)
            begin
               @(negedge core_clk);
               #1;
               chk("out_fall", v ^ 1'(c % 2), pad_out);
            end
            p = v;
         end
      end
      // double-edge transmit, normal alignment
      set_cfg(gio_pkg::GIO_OUTPUT, bitv(gio_pkg::GIO_DDR_BIT));
      p = core_out[0];
      repeat (8)
      begin
         @(posedge core_clk);
         v = 1'($urandom);
         b = 1'($urandom);
         core_out <= {2'h0, b, v};
         #1;
         chk("ddr_out_rise", p, pad_out);
         @(negedge core_clk);
         #1;
         chk("ddr_out_fall", b, pad_out);
         p = v;
      end
      // clock output
      set_cfg(gio_pkg::GIO_CLKOUT, 32'h0);
      for (int k = 0; k < 6; k++)
      begin
         @(posedge core_clk);
         #(1.5 + 3 * k);
         chk("clk_out", clk_tree, pad_out);
         chk("clk_oe", 1, pad_oe);
      end
      // bidirectional, unregistered then registered transmit and enable
      for (int r = 0; r < 2; r++)
      begin
         set_cfg(gio_pkg::GIO_BIDIR, (r == 1) ? (bitv(gio_pkg::GIO_OUT_REG_BIT) | bitv(gio_pkg::GIO_OE_REG_BIT)) : 0);
         po = core_oe;
         pd = core_out[0];
         repeat (10)
         begin
            @(posedge core_clk);
            o = 1'($urandom);
            d = 1'($urandom);
            e = 1'($urandom);
            core_oe <= o;
            core_out <= {3'h0, d};
            ext_val <= e;
            #1;
            if (r == 0)
            begin
               po = o;
               pd = d;
            end
            chk("bidir_oe", po, pad_oe);
            chk("bidir_out", po ? pd : 1'b0, pad_out);
            chk("bidir_in", po ? pd : e, core_in[0]);
            po = o;
            pd = d;
         end
      end
      // serializer looped back through the driven pad into the deserializer
      @(posedge core_clk);
      core_oe <= 1'b1;
      set_cfg(gio_pkg::GIO_BIDIR, bitv(gio_pkg::GIO_SERDES_BIT));
      repeat (2)
      begin
         @(posedge core_clk);
         h = 4'($urandom);
         core_out <= h;
         hits = 0;
         for (int k = 0; k < 12; k++)
         begin
            @(posedge core_clk);
            #1;
            if (k >= 8 && core_word_strobe === 1'b1)
            begin
               hits++;
               chk("ser_loop", h, core_in);
            end
         end
         chk("ser_strobes", 1, hits);
      end
      // idle bidirectional pin: bus hold, then dynamic pull-up over it
      @(posedge core_clk);
      core_oe <= 1'b0;
      set_cfg(gio_pkg::GIO_BIDIR, bitv(gio_pkg::GIO_HOLD_BIT));
      chk("hold_idle", 1, pad_hold);
      chk("hold_pu", 0, pad_pull_up);
      reg_read(gio_pkg::GIO_STAT_OFS, 32'h8 | (ext_val ? 32'h11 : 32'h0));
      set_cfg(gio_pkg::GIO_BIDIR, bitv(gio_pkg::GIO_HOLD_BIT) | bitv(gio_pkg::GIO_DYN_PU_BIT));
      chk("dyn_pu", 1, pad_pull_up);
      chk("dyn_hold", 0, pad_hold);
      wrap_up();
   end
endmodule // gio_io_logic_tb
